// ### core/lmx_pkg.sv
package lmx_pkg;

   // ----------------------------------------
   // opcode encodings (14-bit instruction word)
   // ----------------------------------------
   localparam logic [13:0] LMX_OP_NOP        = 14'h0000;
   localparam logic [13:0] LMX_OP_RESET      = 14'h0001;
   localparam logic [13:0] LMX_MASK_BANK     = 14'h3FE0;
   localparam logic [13:0] LMX_OP_BANK       = 14'h0020;
   localparam logic [13:0] LMX_MASK_PAGE     = 14'h3F80;
   localparam logic [13:0] LMX_OP_PAGE       = 14'h3180;
   localparam logic [13:0] LMX_MASK_ACC      = 14'h3F00;
   localparam logic [13:0] LMX_OP_ACC        = 14'h3000;
   localparam logic [13:0] LMX_MASK_STORE    = 14'h3F80;
   localparam logic [13:0] LMX_OP_STORE      = 14'h0080;
   localparam logic [13:0] LMX_MASK_ISTORE   = 14'h3FF8;
   localparam logic [13:0] LMX_OP_ISTORE     = 14'h0018;
   localparam logic [13:0] LMX_MASK_ISTREL   = 14'h3F80;
   localparam logic [13:0] LMX_OP_ISTREL     = 14'h3F80;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int LMX_PTR_SEL_BIT  = 2;
   localparam int LMX_REL_SEL_BIT  = 6;

   // ----------------------------------------
   // pointer mode field values
   // ----------------------------------------
   localparam logic [1:0] LMX_MM_PREINC  = 2'h0;
   localparam logic [1:0] LMX_MM_PREDEC  = 2'h1;
   localparam logic [1:0] LMX_MM_POSTINC = 2'h2;
   localparam logic [1:0] LMX_MM_POSTDEC = 2'h3;

   // ----------------------------------------
   // reset values and pointer step
   // ----------------------------------------
   localparam logic [4:0]  LMX_BANK_RST   = 5'h00;
   localparam logic [6:0]  LMX_PAGE_RST   = 7'h00;
   localparam logic [7:0]  LMX_ACC_RST    = 8'h00;
   localparam logic [15:0] LMX_PTR_RST    = 16'h0000;
   localparam logic [15:0] LMX_PC_RST     = 16'h0000;
   localparam logic [15:0] LMX_PTR_ONE    = 16'h0001;

   typedef enum logic [2:0] {
      LMX_I_NONE,
      LMX_I_NOP,
      LMX_I_BANK,
      LMX_I_PAGE,
      LMX_I_ACC,
      LMX_I_STORE,
      LMX_I_ISTORE,
      LMX_I_RESET
   } lmx_instr_t;

endpackage

// ### core/lmx_exec.sv
`timescale 1ns/1ps
// How it works
// RQ1: load_bank_literal writes its 5-bit literal into the bank selection register, no flag touched.
// RQ2: load_page_literal writes its 7-bit literal into the program counter high latch, no flag touched.
// RQ3: load_accumulator_literal puts its 8-bit literal into the working register in one cycle.
// RQ4: store_accumulator writes the working register to the 7-bit addressed file register in one cycle.
// RQ5: indirect_store mode field 00/01/10/11 means preinc, predec, postinc, postdec.
// RQ6: the effective address is pointer+1 or pointer-1 for the pre modes, the pointer itself for the post modes, or pointer plus a signed -32..31 offset.
// RQ7: the pointer ends up +1 for increments, -1 for decrements, unchanged for the offset form.
// RQ8: indirect data locations are virtual, an access goes to the address held in the pointer.
// RQ9: each pointer is 16 bits wide and wraps modulo 65536.
// RQ10: indirect stores and pointer updates never touch a status flag.
// RQ11: the reset instruction performs a full reset and clears the reset instruction flag.
// RQ12: no_operation_instr only advances the program counter in one cycle.
module lmx_exec
   import lmx_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_sys_rst,
   // instruction issue
   input  wire logic        i_instr_valid,
   input  wire logic [13:0] i_instr,
   // register state
   output logic      [4:0]  o_bank_selection_register,
   output logic      [6:0]  o_program_counter_high_latch,
   output logic      [7:0]  o_accumulator,
   output logic      [15:0] o_indirect_pointer0,
   output logic      [15:0] o_indirect_pointer1,
   output logic      [15:0] o_pc,
   output logic             o_reset_instruction_flag,
   output logic             o_status_we,
   // data memory write
   output logic             o_mem_we,
   output logic      [15:0] o_mem_addr,
   output logic      [7:0]  o_mem_wdata,
   // soft reset request
   output logic             o_soft_reset
);

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic op_match(input logic [13:0] w, input logic [13:0] m, input logic [13:0] v);
      return (w & m) == v;
   endfunction

   lmx_instr_t  kind;
   logic        ptr_sel;
   logic [1:0]  mode;
   logic        rel_form;
   logic [15:0] ptr_cur;
   logic [15:0] ptr_nxt;
   logic [15:0] eff_addr;
   logic [15:0] rel_off;
   logic        soft_rst_r;

   // drop anything issued while the soft reset clears state, so nothing re-arms it
   always_comb begin
      kind = LMX_I_NONE;
      if (i_instr_valid && !soft_rst_r) begin // [RQ11]
         if (i_instr == LMX_OP_NOP) begin
            kind = LMX_I_NOP; // [RQ12]
         end else if (i_instr == LMX_OP_RESET) begin
            kind = LMX_I_RESET;
         end else if (op_match(i_instr, LMX_MASK_BANK, LMX_OP_BANK)) begin
            kind = LMX_I_BANK;
         end else if (op_match(i_instr, LMX_MASK_PAGE, LMX_OP_PAGE)) begin
            kind = LMX_I_PAGE;
         end else if (op_match(i_instr, LMX_MASK_ACC, LMX_OP_ACC)) begin
            kind = LMX_I_ACC;
         end else if (op_match(i_instr, LMX_MASK_STORE, LMX_OP_STORE)) begin
            kind = LMX_I_STORE;
         end else if (op_match(i_instr, LMX_MASK_ISTORE, LMX_OP_ISTORE) ||
                      op_match(i_instr, LMX_MASK_ISTREL, LMX_OP_ISTREL)) begin
            kind = LMX_I_ISTORE;
         end
      end
   end

   // ----------------------------------------
   // indirect address generation
   // ----------------------------------------
   assign rel_form = op_match(i_instr, LMX_MASK_ISTREL, LMX_OP_ISTREL);
   assign ptr_sel  = rel_form ? i_instr[LMX_REL_SEL_BIT] : i_instr[LMX_PTR_SEL_BIT];
   assign mode     = i_instr[1:0];
   assign ptr_cur  = ptr_sel ? o_indirect_pointer1 : o_indirect_pointer0;
   assign rel_off  = {{10{i_instr[5]}}, i_instr[5:0]}; // [RQ6]

   // 16-bit adders wrap naturally, no range check needed
   always_comb begin
      eff_addr = ptr_cur;
      ptr_nxt  = ptr_cur;
      if (rel_form) begin
         eff_addr = ptr_cur + rel_off; // [RQ6] [RQ7]
      end else begin
         case (mode) // [RQ5]
            LMX_MM_PREINC: begin
               eff_addr = ptr_cur + LMX_PTR_ONE; // [RQ6]
               ptr_nxt  = ptr_cur + LMX_PTR_ONE; // [RQ9]
            end
            LMX_MM_PREDEC: begin
               eff_addr = ptr_cur - LMX_PTR_ONE;
               ptr_nxt  = ptr_cur - LMX_PTR_ONE; // [RQ9]
            end
            LMX_MM_POSTINC: begin
               ptr_nxt  = ptr_cur + LMX_PTR_ONE; // [RQ7]
            end
            LMX_MM_POSTDEC: begin
               ptr_nxt  = ptr_cur - LMX_PTR_ONE; // [RQ7]
            end
            default: begin
               ptr_nxt  = ptr_cur;
            end
         endcase
      end
   end

   // ----------------------------------------
   // architectural registers
   // ----------------------------------------
   // soft reset is a registered reset of all state except the reset flag, one cycle after the instruction
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst || soft_rst_r) begin // [RQ11]
         o_bank_selection_register    <= LMX_BANK_RST;
         o_program_counter_high_latch <= LMX_PAGE_RST;
         o_accumulator                <= LMX_ACC_RST;
         o_indirect_pointer0          <= LMX_PTR_RST;
         o_indirect_pointer1          <= LMX_PTR_RST;
      end else begin
         case (kind)
            LMX_I_BANK:  o_bank_selection_register    <= i_instr[4:0]; // [RQ1]
            LMX_I_PAGE:  o_program_counter_high_latch <= i_instr[6:0]; // [RQ2]
            LMX_I_ACC:   o_accumulator                <= i_instr[7:0]; // [RQ3]
            LMX_I_ISTORE: begin
               if (ptr_sel) begin
                  o_indirect_pointer1 <= ptr_nxt; // [RQ7]
               end else begin
                  o_indirect_pointer0 <= ptr_nxt;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // program counter
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst || soft_rst_r) begin
         o_pc <= LMX_PC_RST;
      end else if (kind != LMX_I_NONE && kind != LMX_I_RESET) begin
         o_pc <= o_pc + LMX_PTR_ONE; // [RQ12]
      end
   end

   // ----------------------------------------
   // soft reset and reset flag
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= (kind == LMX_I_RESET); // [RQ11]
      end
   end

   // flag is active-low style: set by power-on, cleared by the reset instruction
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_reset_instruction_flag <= 1'b1;
      end else if (kind == LMX_I_RESET) begin
         o_reset_instruction_flag <= 1'b0; // [RQ11]
      end
   end

   assign o_soft_reset = soft_rst_r;
   assign o_status_we  = 1'b0; // [RQ10]

   // ----------------------------------------
   // memory write port
   // ----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst || soft_rst_r) begin
         o_mem_we    <= 1'b0;
         o_mem_addr  <= LMX_PTR_RST;
         o_mem_wdata <= LMX_ACC_RST;
      end else begin
         o_mem_we    <= (kind == LMX_I_STORE) || (kind == LMX_I_ISTORE);
         o_mem_wdata <= o_accumulator;
         if (kind == LMX_I_STORE) begin
            o_mem_addr <= {o_bank_selection_register, 4'h0, i_instr[6:0]}; // [RQ4]
         end else begin
            o_mem_addr <= eff_addr; // [RQ8]
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_bank;
      @(posedge i_clk_sys) disable iff (i_sys_rst || soft_rst_r)
      (kind == LMX_I_BANK) |=> (o_bank_selection_register == $past(i_instr[4:0]));
   endproperty
   a_bank: assert property (p_bank) else $error("bank literal not loaded"); // [RQ1]

   property p_page;
      @(posedge i_clk_sys) disable iff (i_sys_rst || soft_rst_r)
      (kind == LMX_I_PAGE) |=> (o_program_counter_high_latch == $past(i_instr[6:0]));
   endproperty
   a_page: assert property (p_page) else $error("page literal not loaded"); // [RQ2]

   property p_acc;
      @(posedge i_clk_sys) disable iff (i_sys_rst || soft_rst_r)
      (kind == LMX_I_ACC) |=> (o_accumulator == $past(i_instr[7:0]));
   endproperty
   a_acc: assert property (p_acc) else $error("accumulator literal not loaded"); // [RQ3]

   property p_store;
      @(posedge i_clk_sys) disable iff (i_sys_rst || soft_rst_r)
      (kind == LMX_I_STORE) |=> (o_mem_we && o_mem_wdata == $past(o_accumulator)
                                 && o_mem_addr[6:0] == $past(i_instr[6:0]));
   endproperty
   a_store: assert property (p_store) else $error("store write wrong"); // [RQ4]

   property p_preinc;
      @(posedge i_clk_sys) disable iff (i_sys_rst || soft_rst_r)
      (kind == LMX_I_ISTORE && !rel_form && mode == LMX_MM_PREINC)
         |=> (o_mem_addr == $past(ptr_cur) + LMX_PTR_ONE);
   endproperty
   a_preinc: assert property (p_preinc) else $error("preincrement address wrong"); // [RQ5]

   property p_rel;
      @(posedge i_clk_sys) disable iff (i_sys_rst || soft_rst_r)
      (kind == LMX_I_ISTORE && rel_form) |=> (o_mem_addr == $past(ptr_cur) + $past(rel_off));
   endproperty
   a_rel: assert property (p_rel) else $error("relative address wrong"); // [RQ6]

   property p_postdec;
      @(posedge i_clk_sys) disable iff (i_sys_rst || soft_rst_r)
      (kind == LMX_I_ISTORE && !rel_form && mode == LMX_MM_POSTDEC && !ptr_sel)
         |=> (o_indirect_pointer0 == $past(o_indirect_pointer0) - LMX_PTR_ONE
              && o_mem_addr == $past(o_indirect_pointer0));
   endproperty
   a_postdec: assert property (p_postdec) else $error("postdecrement wrong"); // [RQ7]

   property p_wrap;
      @(posedge i_clk_sys) disable iff (i_sys_rst || soft_rst_r)
      (kind == LMX_I_ISTORE && !rel_form && mode == LMX_MM_POSTINC && !ptr_sel
       && o_indirect_pointer0 == 16'hFFFF) |=> (o_indirect_pointer0 == 16'h0000);
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // [RQ9]

   property p_nostatus;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      !o_status_we;
   endproperty
   a_nostatus: assert property (p_nostatus) else $error("status written"); // [RQ10]

   property p_reset;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (kind == LMX_I_RESET) |=> (o_soft_reset && !o_reset_instruction_flag) ##1 (o_pc == LMX_PC_RST);
   endproperty
   a_reset: assert property (p_reset) else $error("soft reset wrong"); // [RQ11]

   property p_nop;
      @(posedge i_clk_sys) disable iff (i_sys_rst || soft_rst_r)
      (kind == LMX_I_NOP) |=> (o_pc == $past(o_pc) + LMX_PTR_ONE && !o_mem_we
                               && $stable(o_accumulator));
   endproperty
   a_nop: assert property (p_nop) else $error("nop changed state"); // [RQ12]

   c_istore: cover property (@(posedge i_clk_sys) kind == LMX_I_ISTORE && !rel_form);
   c_rel:    cover property (@(posedge i_clk_sys) kind == LMX_I_ISTORE && rel_form);
   c_reset:  cover property (@(posedge i_clk_sys) kind == LMX_I_RESET);
   c_store:  cover property (@(posedge i_clk_sys) kind == LMX_I_STORE);

endmodule // lmx_exec

// ### testbench/lmx_exec_tb_top.sv
`timescale 1ns/1ps
module lmx_exec_tb_top;
   import lmx_pkg::*;

   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        i_clk_sys;
   logic        i_sys_rst;
   logic        i_instr_valid;
   logic [13:0] i_instr;
   logic [4:0]  bank;
   logic [6:0]  page;
   logic [7:0]  acc;
   logic [15:0] ptr0;
   logic [15:0] ptr1;
   logic [15:0] pc;
   logic        rflag;
   logic        st_we;
   logic        mem_we;
   logic [15:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic        soft_rst;
   int          failures;
   int          total_checks;
   logic [15:0] e_bank, e_page, e_acc, e_p0, e_p1, e_pc;

   lmx_exec u_dut (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .o_bank_selection_register(bank), .o_program_counter_high_latch(page), .o_accumulator(acc),
      .o_indirect_pointer0(ptr0), .o_indirect_pointer1(ptr1), .o_pc(pc),
      .o_reset_instruction_flag(rflag), .o_status_we(st_we), .o_mem_we(mem_we),
      .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_soft_reset(soft_rst));

   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_regs();
      chk(16'(bank), e_bank);
      chk(16'(page), e_page);
      chk(16'(acc), e_acc);
      chk(ptr0, e_p0);
      chk(ptr1, e_p1);
      chk(pc, e_pc);
      chk_bit(st_we, 1'b0);
   endtask

   // valid stays high so instructions can run back to back
   task automatic exec(input logic [13:0] w);
      i_instr_valid = 1'b1;
      i_instr = w;
      @(posedge i_clk_sys);
      #1;
   endtask

   task automatic istore(input logic [13:0] w, input logic [15:0] ea, input logic [15:0] p0, input logic [15:0] p1);
      exec(w);
      e_pc = e_pc + 16'h0001;
      e_p0 = p0;
      e_p1 = p1;
      chk_bit(mem_we, 1'b1);
      chk(mem_addr, ea);
      chk(16'(mem_wdata), e_acc);
      chk_regs();
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_literals();
      exec(LMX_OP_BANK | 14'h001F);
      e_bank = 16'h001F;
      e_pc = e_pc + 16'h0001;
      chk_regs();
      exec(LMX_OP_PAGE | 14'h007F);
      e_page = 16'h007F;
      e_pc = e_pc + 16'h0001;
      chk_regs();
      exec(LMX_OP_ACC | 14'h00FF);
      e_acc = 16'h00FF;
      e_pc = e_pc + 16'h0001;
      chk_regs();
   endtask

   task automatic t_store();
      exec(LMX_OP_ACC | 14'h004F);
      exec(LMX_OP_STORE | 14'h007F);
      e_acc = 16'h004F;
      e_pc = e_pc + 16'h0002;
      chk_bit(mem_we, 1'b1);
      chk(mem_addr, 16'hF87F);
      chk(16'(mem_wdata), 16'h004F);
      chk_regs();
      exec(LMX_OP_BANK);
      exec(LMX_OP_STORE);
      e_bank = 16'h0000;
      e_pc = e_pc + 16'h0002;
      chk(mem_addr, 16'h0000);
      chk(16'(mem_wdata), 16'h004F);
   endtask

   task automatic t_indirect();
      exec(LMX_OP_ACC | 14'h00A5);
      e_acc = 16'h00A5;
      e_pc = e_pc + 16'h0001;
      istore(LMX_OP_ISTORE | 14'h0000, 16'h0001, 16'h0001, 16'h0000);
      istore(LMX_OP_ISTORE | 14'h0001, 16'h0000, 16'h0000, 16'h0000);
      istore(LMX_OP_ISTORE | 14'h0003, 16'h0000, 16'hFFFF, 16'h0000);
      istore(LMX_OP_ISTORE | 14'h0002, 16'hFFFF, 16'h0000, 16'h0000);
      istore(LMX_OP_ISTORE | 14'h0003, 16'h0000, 16'hFFFF, 16'h0000);
      istore(LMX_OP_ISTORE | 14'h0000, 16'h0000, 16'h0000, 16'h0000);
      istore(LMX_OP_ISTORE | 14'h0004, 16'h0001, 16'h0000, 16'h0001);
      istore(14'h3FE0, 16'hFFE1, 16'h0000, 16'h0001);
      istore(14'h3FDF, 16'h0020, 16'h0000, 16'h0001);
      istore(14'h3F80, 16'h0000, 16'h0000, 16'h0001);
   endtask

   task automatic t_nop();
      exec(LMX_OP_NOP);
      e_pc = e_pc + 16'h0001;
      chk_regs();
      chk_bit(mem_we, 1'b0);
      // unknown opcode must not advance anything
      exec(14'h0002);
      chk_regs();
   endtask

   task automatic t_soft_reset();
      exec(LMX_OP_RESET);
      chk_bit(soft_rst, 1'b1);
      chk_bit(rflag, 1'b0);
      exec(LMX_OP_ACC | 14'h0077);
      {e_bank, e_page, e_acc, e_p0, e_p1, e_pc} = '0;
      chk_regs();
      chk_bit(rflag, 1'b0);
      exec(LMX_OP_ACC | 14'h003C);
      e_acc = 16'h003C;
      e_pc = 16'h0001;
      chk_regs();
      i_instr_valid = 1'b0;
      i_sys_rst = 1'b1;
      @(posedge i_clk_sys);
      #1;
      i_sys_rst = 1'b0;
      chk_bit(rflag, 1'b1);
   endtask

   task automatic finish_test();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      failures = 0;
      total_checks = 0;
      i_sys_rst = 1'b1;
      i_instr_valid = 1'b0;
      i_instr = 14'h0000;
      {e_bank, e_page, e_acc, e_p0, e_p1, e_pc} = '0;
      repeat (5) @(posedge i_clk_sys);
      #1;
      i_sys_rst = 1'b0;
      chk_regs();
      chk_bit(rflag, 1'b1);
      t_literals();
      t_store();
      t_indirect();
      t_nop();
      t_soft_reset();
      finish_test();
   end

   // bound on the whole run, a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge i_clk_sys);
      failures++;
      finish_test();
   end

endmodule // lmx_exec_tb_top
